// ===== hdl/psf_cmd.sv
// Code-state and file-activation command block with AXI4-Lite register access
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1: Enable-code refused when the code is already enabled or blocked.
// R2: Correct code on enable reloads code tries to 3 and enables it.
// R3: Wrong code on enable decrements code tries; code stays disabled.
// R4: Third consecutive wrong code blocks it; optionally also enables; only unblock clears.
// R5: Blocked and disabled grants access; blocked and enabled never grants.
// R6: Enabling the code cancels the alternative replacement: usage qualifier becomes 00.
// R7: Terminal sends enable with P1 00, length 08, 8-byte code, no Le.
// R8: Unblock always accepted; correct key installs new code, reloads 10 and 3.
// R9: After successful unblock the code is enabled and its access satisfied.
// R10: Wrong unblock key decrements only unblock tries; code status untouched.
// R11: Tenth consecutive wrong unblock key blocks it and answers 63C0.
// R12: Every unblock after the key is blocked answers 6983.
// R13: Unblock with empty data reports remaining tries as 63CX, no change.
// R14: Failed unblock on unblocked key returns remaining tries in low nibble.
// R15: Terminal sends unblock with P1 00, length 00 or 10, no Le.
// R16: Deactivate only when its access condition holds; set the file lifecycle flag.
// R17: Successful deactivate makes target current; failure keeps current file unchanged.
// R18: Deactivated file is unusable except for selection and reactivation.
// R19: File commands need P2 00; P1 00 id, 08 root path, 09 current path.
// R20: P1 and P2 00 with empty data act on the current file.
// R21: Reactivate only when its access condition holds; clear the lifecycle flag.
// R22: Successful reactivate makes target current; failure keeps current file unchanged.
// R23: P2 names the code: bit8 scope, bits7-6 zero, number 01 to 1F.
// R24: Reserved P1 on file commands answers an error and changes nothing.
module psf_cmd #(
	parameter int NF = 4,
	parameter logic [7:0] CODE_P2 = 8'h01,
	parameter logic [63:0] CODE_INIT = 64'h3030303030303030,
	parameter logic [63:0] UNBLK_KEY = 64'h3131313131313131,
	parameter bit BLOCK_SETS_EN = 1'b0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic awvalid,
	output logic awready,
	input wire logic [psf_pkg::ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [psf_pkg::ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic code_ac_ok,
	output logic cur_file_usable
);
	localparam int IW = (NF > 1) ? $clog2(NF) : 1;

	typedef struct packed {
		logic aw_ok;
		logic [psf_pkg::ADDR_W-1:0] awa;
		logic w_ok;
		logic [31:0] wd;
		logic [3:0] ws;
		logic bv;
		logic [1:0] br;
		logic rv;
		logic [1:0] rr;
		logic [31:0] rd;
		logic [31:0] cmd;
		logic [127:0] dat;
		logic [15:0] sw;
		logic [63:0] code;
		logic enabled;
		logic verified;
		logic [7:0] alt;
		logic [IW-1:0] cur;
		logic cur_ok;
		psf_pkg::psf_file_t [NF-1:0] files;
	} psf_state_t;

	psf_state_t s_q;
	psf_state_t s_d;

	logic [psf_pkg::CODE_TRY_W-1:0] ctry;
	logic [psf_pkg::UNBLK_TRY_W-1:0] utry;
	logic cblk;
	logic ublk;
	logic cdec;
	logic crel;
	logic udec;
	logic urel;
	logic exec;
	logic go;
	logic [31:0] cv;
	psf_pkg::psf_op_t cop;
	logic [7:0] p1;
	logic [7:0] p2;
	logic [7:0] lc;
	logic p2_ok;
	logic code_match;
	logic ukey_match;
	logic p1_legal;
	logic lc_ok;
	logic fop;
	logic [6:0] lbase;
	logic [15:0] tfid;
	logic [NF-1:0] hit;
	logic tgt_hit;
	logic [IW-1:0] tgt;
	logic ac_met;
	logic file_ok;
	logic [7:0] wa;
	logic [7:0] ra;
	logic [5:0] wfi;
	logic [5:0] rfi;
	logic [31:0] rword;
	logic rerr;
	logic [31:0] code_w;

	psf_try_ctr #(.W(psf_pkg::CODE_TRY_W), .INIT(psf_pkg::CODE_TRIES)) u_code_ctr (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.dec(cdec),
		.reload(crel),
		.count(ctry),
		.zero(cblk)
	);

	psf_try_ctr #(.W(psf_pkg::UNBLK_TRY_W), .INIT(psf_pkg::UNBLK_TRIES)) u_unblk_ctr (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.dec(udec),
		.reload(urel),
		.count(utry),
		.zero(ublk)
	);

	// Command fields come from the word being written, so execution starts with the write
	assign cv = psf_pkg::psf_merge(s_q.cmd, s_q.wd, s_q.ws);
	assign cop = psf_pkg::psf_op_t'(cv[psf_pkg::CMD_OP_LSB +: 2]);
	assign p1 = cv[psf_pkg::CMD_P1_LSB +: 8];
	assign p2 = cv[psf_pkg::CMD_P2_LSB +: 8];
	assign lc = cv[psf_pkg::CMD_LC_LSB +: 8];
	assign exec = s_q.aw_ok && s_q.w_ok && !s_q.bv && (wa == psf_pkg::OFF_CMD);
	assign go = exec && ce;
	assign p2_ok = (p2 == CODE_P2) && (p2[6:5] == 2'h0) && (p2[4:0] != 5'h00); // R23
	assign code_match = (s_q.dat[63:0] == s_q.code);
	assign ukey_match = (s_q.dat[63:0] == UNBLK_KEY);
	assign fop = (cop == psf_pkg::PSF_OP_DEACT) || (cop == psf_pkg::PSF_OP_ACT);
	assign p1_legal = (p1 == psf_pkg::P1_NONE) || (p1 == psf_pkg::P1_PATH_ROOT) ||
		(p1 == psf_pkg::P1_PATH_CUR); // R19
	assign lc_ok = (p1 == psf_pkg::P1_NONE) ?
		((lc == psf_pkg::LC_EMPTY) || (lc == psf_pkg::LC_FID)) :
		(!lc[0] && (lc != psf_pkg::LC_EMPTY) && (lc <= psf_pkg::LC_PATH_MAX));
	// Target identifier is the last two bytes of the data field, first byte high
	assign lbase = {lc[3:0] - 4'h2, 3'b000};
	assign tfid = {s_q.dat[lbase +: 8], s_q.dat[7'(lbase + 7'h08) +: 8]};

	for (genvar i = 0; i < NF; i++) begin : g_lookup
		assign hit[i] = (s_q.files[i].fid == tfid);
	end

	always_comb begin
		tgt = s_q.cur;
		tgt_hit = 1'b0;
		if ((p1 == psf_pkg::P1_NONE) && (lc == psf_pkg::LC_EMPTY)) begin
			tgt_hit = s_q.cur_ok; // R20
		end else begin
			for (int i = NF - 1; i >= 0; i--) begin
				if (hit[i]) begin
					tgt = IW'(i);
					tgt_hit = 1'b1;
				end
			end
		end
	end

	assign ac_met = (cop == psf_pkg::PSF_OP_DEACT) ? s_q.files[tgt].dac : s_q.files[tgt].aac;
	assign file_ok = fop && (p2 == psf_pkg::P2_NONE) && p1_legal && lc_ok &&
		tgt_hit && ac_met && !((cop == psf_pkg::PSF_OP_DEACT) && s_q.files[tgt].off); // R18
	// Enabled bit is writable: the disable function lives outside this block
	assign code_w = psf_pkg::psf_merge({8'h00, s_q.alt, 13'h0000, s_q.enabled, 2'h0}, s_q.wd,
		s_q.ws);
	assign wa = {s_q.awa[7:2], 2'b00};
	assign ra = {araddr[7:2], 2'b00};
	assign wfi = wa[7:2] - psf_pkg::FILE_BASE[7:2];
	assign rfi = ra[7:2] - psf_pkg::FILE_BASE[7:2];

	always_comb begin
		s_d = s_q;
		cdec = 1'b0;
		crel = 1'b0;
		udec = 1'b0;
		urel = 1'b0;
		rword = 32'h0000_0000;
		rerr = 1'b0;
		// Address and data may arrive in either order
		if (awvalid && !s_q.aw_ok) begin
			s_d.aw_ok = 1'b1;
			s_d.awa = awaddr;
		end
		if (wvalid && !s_q.w_ok) begin
			s_d.w_ok = 1'b1;
			s_d.wd = wdata;
			s_d.ws = wstrb;
		end
		if (bready && s_q.bv) begin
			s_d.bv = 1'b0;
		end
		if (s_q.aw_ok && s_q.w_ok && !s_q.bv) begin
			s_d.aw_ok = 1'b0;
			s_d.w_ok = 1'b0;
			s_d.bv = 1'b1;
			s_d.br = psf_pkg::RESP_OKAY;
			if (wa == psf_pkg::OFF_CMD) begin
				s_d.cmd = cv;
			end else if (wa == psf_pkg::OFF_CODE) begin
				s_d.alt = code_w[psf_pkg::CST_ALT_LSB +: 8];
				s_d.enabled = code_w[psf_pkg::CST_EN_BIT];
			end else if ((wa & psf_pkg::DATA_MASK) == psf_pkg::DATA_BASE) begin
				s_d.dat[32*wa[3:2] +: 32] = psf_pkg::psf_merge(s_q.dat[32*wa[3:2] +: 32],
					s_q.wd, s_q.ws);
			end else if ((wa >= psf_pkg::FILE_BASE) && (wfi < 6'(NF))) begin
				{s_d.files[wfi[IW-1:0]].aac, s_d.files[wfi[IW-1:0]].dac,
					s_d.files[wfi[IW-1:0]].fid} = 18'(psf_pkg::psf_merge(
					{14'h0000, s_q.files[wfi[IW-1:0]].aac, s_q.files[wfi[IW-1:0]].dac,
					s_q.files[wfi[IW-1:0]].fid}, s_q.wd, s_q.ws));
			end else if ((wa != psf_pkg::OFF_RESP) && (wa != psf_pkg::OFF_CUR)) begin
				s_d.br = psf_pkg::RESP_SLVERR;
			end
		end
		if (exec) begin
			unique case (cop)
			psf_pkg::PSF_OP_ENABLE: begin
				if ((p1 != psf_pkg::P1_NONE) || !p2_ok) begin
					s_d.sw = psf_pkg::SW_BAD_P1P2;
				end else if (lc != psf_pkg::LC_CODE) begin
					s_d.sw = psf_pkg::SW_BAD_LEN;
				end else if (s_q.enabled || cblk) begin
					s_d.sw = psf_pkg::SW_NOT_ALLOWED; // R1
				end else if (code_match) begin
					crel = 1'b1; // R2
					s_d.enabled = 1'b1; // R2
					s_d.verified = 1'b1;
					s_d.alt = psf_pkg::ALT_DONT_USE; // R6
					s_d.sw = psf_pkg::SW_OK;
				end else begin
					cdec = 1'b1; // R3
					s_d.verified = 1'b0;
					if (ctry == psf_pkg::CODE_TRY_W'(1)) begin
						s_d.enabled = BLOCK_SETS_EN; // R4
					end
					s_d.sw = {psf_pkg::SW_RETRY_HI, 4'(ctry - psf_pkg::CODE_TRY_W'(1))};
				end
			end
			psf_pkg::PSF_OP_UNBLOCK: begin
				if ((p1 != psf_pkg::P1_NONE) || !p2_ok) begin
					s_d.sw = psf_pkg::SW_BAD_P1P2;
				end else if (ublk) begin
					s_d.sw = psf_pkg::SW_UNBLK_BLOCKED; // R12
				end else if (lc == psf_pkg::LC_EMPTY) begin
					s_d.sw = {psf_pkg::SW_RETRY_HI, utry}; // R13
				end else if (lc != psf_pkg::LC_UNBLOCK) begin
					s_d.sw = psf_pkg::SW_BAD_LEN;
				end else if (ukey_match) begin
					s_d.code = s_q.dat[127:64]; // R8
					urel = 1'b1; // R8
					crel = 1'b1; // R8
					s_d.enabled = 1'b1; // R9
					s_d.verified = 1'b1; // R9
					s_d.sw = psf_pkg::SW_OK;
				end else begin
					udec = 1'b1; // R10
					s_d.sw = {psf_pkg::SW_RETRY_HI, utry - psf_pkg::UNBLK_TRY_W'(1)}; // R11 R14
				end
			end
			psf_pkg::PSF_OP_DEACT, psf_pkg::PSF_OP_ACT: begin
				if ((p2 != psf_pkg::P2_NONE) || !p1_legal) begin
					s_d.sw = psf_pkg::SW_BAD_P1P2; // R24
				end else if (!lc_ok) begin
					s_d.sw = psf_pkg::SW_BAD_LEN;
				end else if (!tgt_hit) begin
					s_d.sw = psf_pkg::SW_NOT_FOUND; // R17 R22
				end else if (!ac_met) begin
					s_d.sw = psf_pkg::SW_SECURITY; // R16 R21
				end else if ((cop == psf_pkg::PSF_OP_DEACT) && s_q.files[tgt].off) begin
					s_d.sw = psf_pkg::SW_NOT_ALLOWED; // R18
				end else begin
					s_d.files[tgt].off = (cop == psf_pkg::PSF_OP_DEACT); // R16 R21
					s_d.cur = tgt; // R17 R22
					s_d.cur_ok = 1'b1;
					s_d.sw = psf_pkg::SW_OK;
				end
			end
			endcase
		end
		if (rready && s_q.rv) begin
			s_d.rv = 1'b0;
		end
		if (ra == psf_pkg::OFF_CMD) begin
			rword = s_q.cmd;
		end else if (ra == psf_pkg::OFF_RESP) begin
			rword = {16'h0000, s_q.sw};
		end else if (ra == psf_pkg::OFF_CODE) begin
			rword = {8'h00, s_q.alt, 3'h0, ublk, utry, 3'h0, s_q.verified, cblk,
				s_q.enabled, ctry};
		end else if (ra == psf_pkg::OFF_CUR) begin
			rword = {28'(s_q.cur), 1'b0, cur_file_usable, s_q.cur_ok, 1'b0} >> 1;
		end else if ((ra & psf_pkg::DATA_MASK) == psf_pkg::DATA_BASE) begin
			rword = s_q.dat[32*ra[3:2] +: 32];
		end else if ((ra >= psf_pkg::FILE_BASE) && (rfi < 6'(NF))) begin
			rword = {13'h0000, s_q.files[rfi[IW-1:0]]};
		end else begin
			rerr = 1'b1;
		end
		if (arvalid && !s_q.rv) begin
			s_d.rv = 1'b1;
			s_d.rd = rword;
			s_d.rr = rerr ? psf_pkg::RESP_SLVERR : psf_pkg::RESP_OKAY;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
			s_q.code <= CODE_INIT;
			s_q.enabled <= 1'b1;
			s_q.sw <= psf_pkg::SW_RESET;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign awready = !s_q.aw_ok;
	assign wready = !s_q.w_ok;
	assign bvalid = s_q.bv;
	assign bresp = s_q.br;
	assign arready = !s_q.rv;
	assign rvalid = s_q.rv;
	assign rdata = s_q.rd;
	assign rresp = s_q.rr;
	// Blocked code grants only while disabled
	assign code_ac_ok = cblk ? !s_q.enabled : (!s_q.enabled || s_q.verified); // R5
	assign cur_file_usable = s_q.cur_ok && !s_q.files[s_q.cur].off; // R18

	a_enable_refused: assert property ( // R1
		@(posedge aclk) disable iff (!aresetn)
		go && (cop == psf_pkg::PSF_OP_ENABLE) && (p1 == psf_pkg::P1_NONE) && p2_ok &&
		(lc == psf_pkg::LC_CODE) && (s_q.enabled || cblk)
		|=> (s_q.sw == psf_pkg::SW_NOT_ALLOWED) && $stable(ctry))
		else $error("enable accepted on enabled or blocked code");

	a_enable_good: assert property ( // R2
		@(posedge aclk) disable iff (!aresetn)
		go && (cop == psf_pkg::PSF_OP_ENABLE) && (p1 == psf_pkg::P1_NONE) && p2_ok &&
		(lc == psf_pkg::LC_CODE) && !s_q.enabled && !cblk && code_match
		|=> (ctry == 2'h3) && s_q.enabled && (s_q.sw == psf_pkg::SW_OK))
		else $error("correct enable did not reload tries and enable");

	a_enable_bad: assert property ( // R3
		@(posedge aclk) disable iff (!aresetn)
		go && (cop == psf_pkg::PSF_OP_ENABLE) && (p1 == psf_pkg::P1_NONE) && p2_ok &&
		(lc == psf_pkg::LC_CODE) && !s_q.enabled && !cblk && !code_match && (ctry > 2'h1)
		|=> (ctry == $past(ctry) - 2'h1) && !s_q.enabled)
		else $error("wrong enable did not decrement");

	a_block_third: assert property ( // R4
		@(posedge aclk) disable iff (!aresetn)
		go && (cop == psf_pkg::PSF_OP_ENABLE) && (p1 == psf_pkg::P1_NONE) && p2_ok &&
		(lc == psf_pkg::LC_CODE) && !s_q.enabled && !cblk && !code_match && (ctry == 2'h1)
		|=> cblk && (s_q.sw == 16'h63C0) && (s_q.enabled == BLOCK_SETS_EN))
		else $error("third wrong code did not block");

	a_alt_cleared: assert property ( // R6
		@(posedge aclk) disable iff (!aresetn)
		go && (cop == psf_pkg::PSF_OP_ENABLE) && (s_d.sw == psf_pkg::SW_OK)
		|=> (s_q.alt == 8'h00) && code_ac_ok)
		else $error("replacement qualifier not cleared");

	a_unblock_good: assert property ( // R8
		@(posedge aclk) disable iff (!aresetn)
		go && (cop == psf_pkg::PSF_OP_UNBLOCK) && (p1 == psf_pkg::P1_NONE) && p2_ok &&
		!ublk && (lc == psf_pkg::LC_UNBLOCK) && ukey_match
		|=> (utry == 4'hA) && (ctry == 2'h3) && s_q.enabled && code_ac_ok &&
		(s_q.code == $past(s_q.dat[127:64])))
		else $error("correct unblock did not restore state");

	a_unblock_bad: assert property ( // R10
		@(posedge aclk) disable iff (!aresetn)
		go && (cop == psf_pkg::PSF_OP_UNBLOCK) && (p1 == psf_pkg::P1_NONE) && p2_ok &&
		!ublk && (lc == psf_pkg::LC_UNBLOCK) && !ukey_match
		|=> $stable(s_q.enabled) && $stable(cblk) &&
		(s_q.sw == {12'h63C, $past(utry) - 4'h1}))
		else $error("wrong unblock touched code status or bad answer");

	a_unblock_locked: assert property ( // R12
		@(posedge aclk) disable iff (!aresetn)
		go && (cop == psf_pkg::PSF_OP_UNBLOCK) && (p1 == psf_pkg::P1_NONE) && p2_ok && ublk
		|=> (s_q.sw == 16'h6983) && $stable(s_q.code))
		else $error("blocked unblock key not answered 6983");

	a_unblock_query: assert property ( // R13
		@(posedge aclk) disable iff (!aresetn)
		go && (cop == psf_pkg::PSF_OP_UNBLOCK) && (p1 == psf_pkg::P1_NONE) && p2_ok &&
		!ublk && (lc == psf_pkg::LC_EMPTY)
		|=> (s_q.sw == {12'h63C, $past(utry)}) && $stable(utry) && $stable(ctry))
		else $error("unblock query wrong or changed state");

	a_file_keep: assert property ( // R17
		@(posedge aclk) disable iff (!aresetn)
		go && fop && !file_ok |=> $stable(s_q.cur) && $stable(s_q.cur_ok))
		else $error("failed file command moved the current file");

	a_reserved_p1: assert property ( // R24
		@(posedge aclk) disable iff (!aresetn)
		go && fop && !p1_legal |=> (s_q.sw == 16'h6A86) && $stable(s_q.files))
		else $error("reserved selection not refused");
endmodule // psf_cmd
`default_nettype wire

// ===== hdl/psf_pkg.sv
// Constants, register map and types for the code-state and file-activation command block
package psf_pkg;
	localparam int ADDR_W = 8;
	// Register byte offsets
	localparam logic [7:0] OFF_CMD = 8'h00;
	localparam logic [7:0] OFF_RESP = 8'h04;
	localparam logic [7:0] OFF_CODE = 8'h08;
	localparam logic [7:0] OFF_CUR = 8'h0C;
	localparam logic [7:0] DATA_BASE = 8'h10;
	localparam logic [7:0] DATA_MASK = 8'hF0;
	localparam logic [7:0] FILE_BASE = 8'h20;
	// Command register fields
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_P1_LSB = 8;
	localparam int CMD_P2_LSB = 16;
	localparam int CMD_LC_LSB = 24;
	// Code status register fields
	localparam int CST_EN_BIT = 2;
	localparam int CST_BLK_BIT = 3;
	localparam int CST_VER_BIT = 4;
	localparam int CST_UTRY_LSB = 8;
	localparam int CST_UBLK_BIT = 12;
	localparam int CST_ALT_LSB = 16;
	// File entry register fields
	localparam int FE_DAC_BIT = 16;
	localparam int FE_AAC_BIT = 17;
	localparam int FE_OFF_BIT = 18;
	// Try counters
	localparam int CODE_TRY_W = 2;
	localparam int UNBLK_TRY_W = 4;
	localparam logic [CODE_TRY_W-1:0] CODE_TRIES = 2'h3;
	localparam logic [UNBLK_TRY_W-1:0] UNBLK_TRIES = 4'hA;
	// Command parameter values
	localparam logic [7:0] P1_NONE = 8'h00;
	localparam logic [7:0] P1_PATH_ROOT = 8'h08;
	localparam logic [7:0] P1_PATH_CUR = 8'h09;
	localparam logic [7:0] P2_NONE = 8'h00;
	localparam logic [7:0] LC_EMPTY = 8'h00;
	localparam logic [7:0] LC_CODE = 8'h08;
	localparam logic [7:0] LC_UNBLOCK = 8'h10;
	localparam logic [7:0] LC_FID = 8'h02;
	localparam logic [7:0] LC_PATH_MAX = 8'h10;
	localparam logic [7:0] ALT_DONT_USE = 8'h00;
	// Status words
	localparam logic [15:0] SW_OK = 16'h9000;
	localparam logic [11:0] SW_RETRY_HI = 12'h63C;
	localparam logic [15:0] SW_UNBLK_BLOCKED = 16'h6983;
	localparam logic [15:0] SW_NOT_ALLOWED = 16'h6985;
	localparam logic [15:0] SW_SECURITY = 16'h6982;
	localparam logic [15:0] SW_BAD_P1P2 = 16'h6A86;
	localparam logic [15:0] SW_BAD_LEN = 16'h6700;
	localparam logic [15:0] SW_NOT_FOUND = 16'h6A82;
	localparam logic [15:0] SW_RESET = 16'h0000;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {PSF_OP_ENABLE, PSF_OP_UNBLOCK, PSF_OP_DEACT, PSF_OP_ACT} psf_op_t;

	typedef struct packed {
		logic off;
		logic aac;
		logic dac;
		logic [15:0] fid;
	} psf_file_t;

	function automatic logic [31:0] psf_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction
endpackage

// ===== hdl/psf_try_ctr.sv
// Down counter of remaining tries with reload, loaded with INIT on reset
`timescale 1ns/1ps
`default_nettype none
module psf_try_ctr #(
	parameter int W = 4,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic dec,
	input wire logic reload,
	output logic [W-1:0] count,
	output logic zero
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} psf_ctr_st_t;

	psf_ctr_st_t s_q;
	psf_ctr_st_t s_d;

	always_comb begin
		s_d = s_q;
		if (reload) begin
			s_d.cnt = INIT;
		end else if (dec && (s_q.cnt != '0)) begin
			s_d.cnt = s_q.cnt - W'(1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q.cnt <= INIT;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign count = s_q.cnt;
	assign zero = (s_q.cnt == '0);
endmodule // psf_try_ctr
`default_nettype wire

// ===== tb/pin_state_and_file_activation_test.sv
// Self-checking bench for the code-state and file-activation command block
`timescale 1ns/1ps
`default_nettype none
module pin_state_and_file_activation_test;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [2:0] awprot, arprot;
	logic [31:0] wdata, rdata, v;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs;
	logic code_ac_ok, cur_file_usable;
	int fails = 0;
	int compares = 0;
	// Row: write address, write data, read-back address, expected read value
	logic [79:0] rows [35] = '{
		{8'h10, 32'h30303030, 8'h10, 32'h30303030},
		{8'h14, 32'h30303030, 8'h14, 32'h30303030},
		{8'h00, 32'h08010000, 8'h04, 32'h00006985},
		{8'h00, 32'h00010001, 8'h04, 32'h000063CA},
		{8'h00, 32'h10010001, 8'h04, 32'h000063C9},
		{8'h04, 32'hFFFFFFFF, 8'h08, 32'h00000907},
		{8'h10, 32'h31313131, 8'h10, 32'h31313131},
		{8'h14, 32'h31313131, 8'h14, 32'h31313131},
		{8'h18, 32'h0000ABCD, 8'h18, 32'h0000ABCD},
		{8'h1C, 32'h12345678, 8'h1C, 32'h12345678},
		{8'h00, 32'h10010001, 8'h04, 32'h00009000},
		{8'h04, 32'h00000000, 8'h08, 32'h00000A17},
		{8'h20, 32'h00013F00, 8'h20, 32'h00013F00},
		{8'h24, 32'h00022F01, 8'h24, 32'h00022F01},
		{8'h10, 32'h0000012F, 8'h10, 32'h0000012F},
		{8'h00, 32'h02000002, 8'h04, 32'h00006982},
		{8'h04, 32'h00000000, 8'h0C, 32'h00000000},
		{8'h10, 32'h0000003F, 8'h10, 32'h0000003F},
		{8'h00, 32'h02000002, 8'h04, 32'h00009000},
		{8'h04, 32'h00000000, 8'h20, 32'h00053F00},
		{8'h04, 32'h00000000, 8'h0C, 32'h00000001},
		{8'h00, 32'h02000103, 8'h04, 32'h00006A86},
		{8'h00, 32'h02010002, 8'h04, 32'h00006A86},
		{8'h00, 32'h00000003, 8'h04, 32'h00006982},
		{8'h04, 32'h00000000, 8'h0C, 32'h00000001},
		{8'h20, 32'h00033F00, 8'h20, 32'h00073F00},
		{8'h00, 32'h00000003, 8'h04, 32'h00009000},
		{8'h04, 32'h00000000, 8'h20, 32'h00033F00},
		{8'h04, 32'h00000000, 8'h0C, 32'h00000003},
		{8'h10, 32'h003F003F, 8'h10, 32'h003F003F},
		{8'h00, 32'h04000902, 8'h04, 32'h00009000},
		{8'h04, 32'h00000000, 8'h0C, 32'h00000001},
		{8'h10, 32'h0000003F, 8'h10, 32'h0000003F},
		{8'h00, 32'h02000803, 8'h04, 32'h00009000},
		{8'h08, 32'h00550004, 8'h08, 32'h00550A17}
	};
	always #4 aclk = ~aclk;
	psf_cmd dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .awvalid(awvalid),
		.awready(awready), .awaddr(awaddr), .awprot(awprot), .wvalid(wvalid),
		.wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
		.bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.arprot(arprot), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.code_ac_ok(code_ac_ok), .cur_file_usable(cur_file_usable));
	psf_term term (.aclk(aclk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.awprot(awprot), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
		.arready(arready), .araddr(araddr), .arprot(arprot), .rvalid(rvalid),
		.rready(rready), .rdata(rdata), .rresp(rresp));
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wc(input logic [7:0] a, input logic [31:0] d, input logic [7:0] ra,
		input logic [31:0] e);
		term.wr(a, d, rs);
		term.rd(ra, v, rs);
		chk("readback", v, e);
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		#200000;
		fails++;
		conclude();
	end
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		term.rd(8'h08, v, rs);
		chk("code_reset", v, 32'h00000A07);
		chk("ac_reset", {31'h0, code_ac_ok}, 32'h0);
		chk("usable_reset", {31'h0, cur_file_usable}, 32'h0);
		foreach (rows[i]) begin
			wc(rows[i][79:72], rows[i][71:40], rows[i][39:32], rows[i][31:0]);
		end
		chk("ac_ok", {31'h0, code_ac_ok}, 32'h1);
		chk("usable", {31'h0, cur_file_usable}, 32'h1);
		wc(8'h00, 32'h00000002, 8'h04, {16'h0, psf_pkg::SW_OK});
		chk("usable_off", {31'h0, cur_file_usable}, 32'h0);
		wc(8'h00, 32'h00000002, 8'h04, {16'h0, psf_pkg::SW_NOT_ALLOWED});
		wc(8'h08, 32'h00550000, 8'h08, 32'h00550A13);
		chk("ac_disabled", {31'h0, code_ac_ok}, 32'h1);
		wc(8'h00, 32'h08010000, 8'h04, {16'h0, psf_pkg::SW_RETRY_HI, 4'h2});
		term.wr(8'h10, 32'h0000ABCD, rs);
		term.wr(8'h14, 32'h12345678, rs);
		wc(8'h00, 32'h08010000, 8'h04, {16'h0, psf_pkg::SW_OK});
		term.rd(8'h08, v, rs);
		chk("code_enabled", v, 32'h00000A17);
		term.wr(8'h10, 32'h30303030, rs);
		term.wr(8'h14, 32'h30303030, rs);
		wc(8'h08, 32'h00000000, 8'h08, 32'h00000A13);
		for (int i = 0; i < 3; i++) begin
			wc(8'h00, 32'h08010000, 8'h04, {16'h0, psf_pkg::SW_RETRY_HI, 4'(2 - i)});
		end
		term.rd(8'h08, v, rs);
		chk("code_blocked", v, 32'h00000A08);
		chk("ac_blocked_off", {31'h0, code_ac_ok}, 32'h1);
		wc(8'h00, 32'h08010000, 8'h04, {16'h0, psf_pkg::SW_NOT_ALLOWED});
		for (int i = 0; i < 10; i++) begin
			wc(8'h00, 32'h10010001, 8'h04, {16'h0, psf_pkg::SW_RETRY_HI, 4'(9 - i)});
		end
		wc(8'h00, 32'h10010001, 8'h04, {16'h0, psf_pkg::SW_UNBLK_BLOCKED});
		wc(8'h00, 32'h00010001, 8'h04, {16'h0, psf_pkg::SW_UNBLK_BLOCKED});
		term.rd(8'h08, v, rs);
		chk("code_after", v, 32'h00001008);
		chk("ac_kept", {31'h0, code_ac_ok}, 32'h1);
		wc(8'h08, 32'h00000004, 8'h08, 32'h0000100C);
		chk("ac_blocked_on", {31'h0, code_ac_ok}, 32'h0);
		term.rd(8'hFC, v, rs);
		chk("rresp", {30'h0, rs}, {30'h0, psf_pkg::RESP_SLVERR});
		term.wr(8'hFC, 32'h00000001, rs);
		chk("bresp", {30'h0, rs}, {30'h0, psf_pkg::RESP_SLVERR});
		conclude();
	end
endmodule // pin_state_and_file_activation_test
`default_nettype wire

// ===== tb/psf_term.sv
// Terminal model: AXI4-Lite master that issues command register accesses
`timescale 1ns/1ps
`default_nettype none
module psf_term (
	input wire logic aclk,
	output logic awvalid,
	input wire logic awready,
	output logic [7:0] awaddr,
	output logic [2:0] awprot,
	output logic wvalid,
	input wire logic wready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	input wire logic bvalid,
	output logic bready,
	input wire logic [1:0] bresp,
	output logic arvalid,
	input wire logic arready,
	output logic [7:0] araddr,
	output logic [2:0] arprot,
	input wire logic rvalid,
	output logic rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp
);
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, awprot, arprot} = 22'h000000;
		wdata = 32'h00000000;
		wstrb = 4'h0;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hF;
		fork
			begin
				do @(posedge aclk); while (!awready);
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			begin
				do @(posedge aclk); while (!wready);
				wvalid <= 1'b0;
				wdata <= ~d;
			end
		join
		bready <= 1'b1;
		do @(posedge aclk); while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		araddr <= ~a;
		do @(posedge aclk); while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
endmodule // psf_term
`default_nettype wire
